// File: logic/logic_cmp_pkg.sv
// Purpose: Shared constants and types of the logic and compare unit.
// Assumes: 32-bit AXI4-Lite register window with 12 address bits.
// Notes:   Register offsets are byte addresses of aligned words.
package logic_cmp_pkg;
  localparam int          REG_AW       = 12;
  localparam logic [11:0] OFF_CMD      = 12'h000;
  localparam logic [11:0] OFF_ADDR     = 12'h004;
  localparam logic [11:0] OFF_CONST    = 12'h008;
  localparam logic [11:0] OFF_ACC      = 12'h00c;
  localparam logic [11:0] OFF_FLAGS    = 12'h010;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_MEM_BASE = 12'h100;
  localparam logic [11:0] MEM_WIN_MASK = 12'hf00;

  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_SRC_BIT = 4;

  localparam int FLAG_LT   = 0;
  localparam int FLAG_EQ   = 1;
  localparam int FLAG_GT   = 2;
  localparam int FLAG_ZERO = 3;
  localparam int FLAG_NEG  = 4;
  localparam int FLAG_BUSY = 8;

  localparam int IRQ_W       = 2;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_REFUSED = 1;

  localparam logic [31:0]      ACC_RST      = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [1:0]       RESP_OKAY    = 2'h0;
  localparam logic [1:0]       RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    or_double_op,
    xor_single_op,
    exclusive_or_double_op,
    compare_single_op
  } op_sel_t;

  typedef enum logic [1:0] {
    st_idle,
    st_fetch_lo,
    st_fetch_hi,
    st_exec
  } state_t;
endpackage

// File: logic/alu_if.sv
// Purpose: Carries operands and results between sequencer and datapath.
// Assumes: Purely combinational datapath on the unit side.
// Notes:   The upd_* bits say which flags the current operation drives.
interface alu_if;
  import logic_cmp_pkg::*;
  op_sel_t     op;
  logic [31:0] acc;
  logic [31:0] operand;
  logic [31:0] result;
  logic        less;
  logic        equal;
  logic        greater;
  logic        zero;
  logic        negative;
  logic        upd_zero;
  logic        upd_neg;
  logic        upd_cmp;
  modport core (output op, acc, operand,
                input  result, less, equal, greater, zero, negative,
                       upd_zero, upd_neg, upd_cmp);
  modport unit (input  op, acc, operand,
                output result, less, equal, greater, zero, negative,
                       upd_zero, upd_neg, upd_cmp);
endinterface

// File: logic/logic_cmp_alu.sv
// Purpose: Combinational logic and compare datapath.
// Assumes: Operands are stable while the sequencer is in its execute state.
// Notes:   Compare is unsigned on the low halfword.
module logic_cmp_alu
  import logic_cmp_pkg::*;
(
  alu_if.unit bus  // Operands in, result and flags out
);
  always_comb begin
    bus.result   = bus.acc;
    bus.upd_zero = 1'b0;
    bus.upd_neg  = 1'b0;
    bus.upd_cmp  = 1'b0;
    unique case (bus.op)
      or_double_op: begin
        bus.result   = bus.acc | bus.operand;
        bus.upd_zero = 1'b1;
        bus.upd_neg  = 1'b1;
      end
      xor_single_op: begin
        bus.result   = {16'h0000,
                        bus.acc[15:0] ^ bus.operand[15:0]};
        bus.upd_zero = 1'b1;
      end
      exclusive_or_double_op: begin
        bus.result   = bus.acc ^ bus.operand;
        bus.upd_zero = 1'b1;
        bus.upd_neg  = 1'b1;
      end
      compare_single_op: begin
        bus.result   = bus.acc;
        bus.upd_cmp  = 1'b1;
      end
    endcase
  end

  assign bus.zero     = (bus.result == 32'h0000_0000);
  assign bus.negative = bus.result[31];
  assign bus.less     = bus.acc[15:0] <  bus.operand[15:0];
  assign bus.equal    = bus.acc[15:0] == bus.operand[15:0];
  assign bus.greater  = bus.acc[15:0] >  bus.operand[15:0];
endmodule

// File: logic/logic_cmp_unit.sv
// Purpose: Accumulator logic and compare unit with AXI4-Lite registers.
// Assumes: One clock, synchronous active-low reset, aligned word access.
// Notes:   MEM_WORDS must be a power of two no larger than 64.
// Function
// - Double OR merges 32-bit operand into accumulator.
// - Double operand from two memory words or constant.
// - Double OR sets zero and negative flags.
// - Single XOR of low halfword with one word.
// - Single XOR sets zero flag on zero result.
// - Double XOR combines full accumulator with operand.
// - Double XOR sets zero and negative flags.
// - Single compare leaves accumulator untouched.
// - Compare sets less, equal or greater flag.
// - Flags hold until an operation rewrites them.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
module logic_cmp_unit
  import logic_cmp_pkg::*;
#(
  parameter int MEM_WORDS = 16
) (
  input  wire logic              aclk,                 // System clock
  input  wire logic              aresetn,              // Sync reset, low
  input  wire logic [REG_AW-1:0] awaddr,               // Write address
  input  wire logic              awvalid,              // Write addr valid
  output      logic              awready,              // Write addr ready
  input  wire logic [31:0]       wdata,                // Write data
  input  wire logic [3:0]        wstrb,                // Write byte lanes
  input  wire logic              wvalid,               // Write data valid
  output      logic              wready,               // Write data ready
  output      logic [1:0]        bresp,                // Write response
  output      logic              bvalid,               // Response valid
  input  wire logic              bready,               // Response ready
  input  wire logic [REG_AW-1:0] araddr,               // Read address
  input  wire logic              arvalid,              // Read addr valid
  output      logic              arready,              // Read addr ready
  output      logic [31:0]       rdata,                // Read data
  output      logic [1:0]        rresp,                // Read response
  output      logic              rvalid,               // Read data valid
  input  wire logic              rready,               // Read data ready
  output      logic              irq,                  // Level interrupt
  output      logic              less_than_flag,       // Compare below
  output      logic              equal_flag,           // Compare match
  output      logic              greater_than_flag,    // Compare above
  output      logic              zero_result_flag,     // Result is zero
  output      logic              negative_result_flag  // Result msb set
);
  localparam int ADDR_W = $clog2(MEM_WORDS);

  logic [REG_AW-1:0] aw_addr_r;
  logic              aw_have_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_have_r;
  logic              wr_fire;
  logic              wr_cmd;
  logic              wr_addr;
  logic              wr_const;
  logic              wr_acc;
  logic              wr_stat;
  logic              wr_mask;
  logic              wr_mem;
  logic [31:0]       rd_data;
  logic              rd_err;
  state_t            state_r;
  op_sel_t           op_r;
  op_sel_t           cmd_op;
  logic              cmd_const;
  logic              launch;
  logic              refused;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_hi;
  logic [ADDR_W-1:0] mem_addr_r;
  logic [31:0]       const_r;
  logic [31:0]       acc_r;
  logic [31:0]       operand_r;
  logic [15:0]       mem_r [MEM_WORDS];
  logic [15:0]       mem_lo_word;
  logic [15:0]       mem_hi_word;
  logic [IRQ_W-1:0]  irq_status_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic              src_const_r;
  logic [31:0]       wr_lanes;
  logic [31:0]       mem_merged;
  logic [31:0]       mask_merged;

  alu_if au ();

  function automatic logic is_double(input op_sel_t o);
    return (o == or_double_op) || (o == exclusive_or_double_op);
  endfunction

  function automatic logic is_mem(input logic [REG_AW-1:0] a);
    return ((a & MEM_WIN_MASK) == OFF_MEM_BASE) &&
           (int'(a[7:2]) < MEM_WORDS);
  endfunction

  function automatic logic [ADDR_W-1:0] mem_idx(input logic [REG_AW-1:0] a);
    return a[ADDR_W+1:2];
  endfunction

  function automatic logic reg_hit(input logic [REG_AW-1:0] a);
    return is_mem(a) || a == OFF_CMD || a == OFF_ADDR || a == OFF_CONST ||
           a == OFF_ACC || a == OFF_FLAGS || a == OFF_IRQ_STAT ||
           a == OFF_IRQ_MASK;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Address and data are taken in either order; the write happens once
  // both are held and no response is pending.
  assign wr_fire   = aw_have_r && w_have_r && !bvalid;
  assign wr_cmd    = wr_fire && aw_addr_r == OFF_CMD && w_strb_r[0];
  assign wr_addr   = wr_fire && aw_addr_r == OFF_ADDR;
  assign wr_const  = wr_fire && aw_addr_r == OFF_CONST;
  assign wr_acc    = wr_fire && aw_addr_r == OFF_ACC;
  assign wr_stat   = wr_fire && aw_addr_r == OFF_IRQ_STAT;
  assign wr_mask   = wr_fire && aw_addr_r == OFF_IRQ_MASK;
  assign wr_mem    = wr_fire && is_mem(aw_addr_r);

  assign cmd_op    = op_sel_t'(w_data_r[CMD_OP_LSB +: 2]);
  assign cmd_const = w_data_r[CMD_SRC_BIT] && is_double(cmd_op);
  assign launch    = wr_cmd && state_r == st_idle;
  assign refused   = wr_cmd && state_r != st_idle;

  assign addr_hi     = ADDR_W'(addr_r + 1'b1);
  assign mem_lo_word = mem_r[addr_r];
  assign mem_hi_word = mem_r[addr_hi];
  assign wr_lanes    = merge(32'h0000_0000, w_data_r, w_strb_r);
  assign mem_merged  = merge({16'h0000, mem_r[mem_idx(aw_addr_r)]},
                             w_data_r, w_strb_r);
  assign mask_merged = merge({{(32-IRQ_W){1'b0}}, irq_mask_r},
                             w_data_r, w_strb_r);

  assign au.op      = op_r;
  assign au.acc     = acc_r;
  assign au.operand = operand_r;

  logic_cmp_alu u_alu (
    .bus (au.unit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      wready    <= 1'b0;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awready && awvalid) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end else if (!aw_have_r && !bvalid) begin
        awready   <= 1'b1;
      end
      if (wready && wvalid) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready   <= 1'b0;
      end else if (!w_have_r && !bvalid) begin
        wready   <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= reg_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid    <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = !reg_hit(araddr);
    if (is_mem(araddr)) begin
      rd_data[15:0] = mem_r[mem_idx(araddr)];
    end else begin
      case (araddr)
        OFF_CMD: begin
          rd_data[CMD_OP_LSB +: 2] = op_r;
          rd_data[CMD_SRC_BIT]     = src_const_r;
        end
        OFF_ADDR:     rd_data[ADDR_W-1:0] = mem_addr_r;
        OFF_CONST:    rd_data = const_r;
        OFF_ACC:      rd_data = acc_r;
        OFF_FLAGS: begin
          rd_data[FLAG_LT]   = less_than_flag;
          rd_data[FLAG_EQ]   = equal_flag;
          rd_data[FLAG_GT]   = greater_than_flag;
          rd_data[FLAG_ZERO] = zero_result_flag;
          rd_data[FLAG_NEG]  = negative_result_flag;
          rd_data[FLAG_BUSY] = state_r != st_idle;
        end
        OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_status_r;
        OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
        default:      rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arready && arvalid) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_data;
      rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= st_idle;
      op_r        <= or_double_op;
      src_const_r <= 1'b0;
      addr_r      <= '0;
    end else begin
      unique case (state_r)
        st_idle: begin
          if (launch) begin
            op_r        <= cmd_op;
            src_const_r <= cmd_const;
            addr_r      <= mem_addr_r;
            state_r     <= cmd_const ? st_exec : st_fetch_lo;
          end
        end
        st_fetch_lo: state_r <= is_double(op_r) ? st_fetch_hi : st_exec;
        st_fetch_hi: state_r <= st_exec;
        st_exec:     state_r <= st_idle;
      endcase
    end
  end

  // Single-width operations always take their operand from memory.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      operand_r <= 32'h0000_0000;
    end else if (launch && cmd_const) begin
      operand_r <= const_r;
    end else if (state_r == st_fetch_lo) begin
      operand_r <= {16'h0000, mem_lo_word};
    end else if (state_r == st_fetch_hi) begin
      operand_r[31:16] <= mem_hi_word;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= ACC_RST;
    end else if (state_r == st_exec) begin
      acc_r <= au.result;
    end else if (wr_acc && state_r == st_idle) begin
      acc_r <= merge(acc_r, w_data_r, w_strb_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      less_than_flag       <= 1'b0;
      equal_flag           <= 1'b0;
      greater_than_flag    <= 1'b0;
      zero_result_flag     <= 1'b0;
      negative_result_flag <= 1'b0;
    end else if (state_r == st_exec) begin
      if (au.upd_cmp) begin
        less_than_flag    <= au.less;
        equal_flag        <= au.equal;
        greater_than_flag <= au.greater;
      end
      if (au.upd_zero) begin
        zero_result_flag <= au.zero;
      end
      if (au.upd_neg) begin
        negative_result_flag <= au.negative;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (wr_mem) begin
      mem_r[mem_idx(aw_addr_r)] <= mem_merged[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_addr_r <= '0;
      const_r    <= 32'h0000_0000;
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      if (wr_addr) begin
        mem_addr_r <= wr_lanes[ADDR_W-1:0];
      end
      if (wr_const) begin
        const_r <= merge(const_r, w_data_r, w_strb_r);
      end
      if (wr_mask) begin
        irq_mask_r <= mask_merged[IRQ_W-1:0];
      end
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear.
  assign irq_set[IRQ_DONE]    = state_r == st_exec;
  assign irq_set[IRQ_REFUSED] = refused;
  assign irq_clr = wr_stat ? wr_lanes[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
      irq          <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      irq          <= |(irq_status_r & irq_mask_r);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ord_result: assert property (
    state_r == st_exec && op_r == or_double_op |=>
      acc_r == ($past(acc_r) | $past(operand_r)))
    else $error("double OR result wrong");

  a_const_operand: assert property (
    launch && cmd_const |=> operand_r == $past(const_r) ##1
      state_r == st_idle)
    else $error("constant operand not taken");

  a_ord_flags: assert property (
    state_r == st_exec && op_r == or_double_op |=>
      zero_result_flag == (acc_r == 32'h0000_0000) &&
      negative_result_flag == acc_r[31])
    else $error("double OR flags wrong");

  a_xor_low: assert property (
    state_r == st_exec && op_r == xor_single_op |=>
      acc_r == {16'h0000, $past(acc_r[15:0]) ^ $past(operand_r[15:0])})
    else $error("single XOR result wrong");

  a_xor_zero: assert property (
    state_r == st_exec && op_r == xor_single_op |=>
      zero_result_flag == (acc_r == 32'h0000_0000))
    else $error("single XOR zero flag wrong");

  a_exclusive_or_double_op_result: assert property (
    state_r == st_exec && op_r == exclusive_or_double_op |=>
      acc_r == ($past(acc_r) ^ $past(operand_r)))
    else $error("double XOR result wrong");

  a_exclusive_or_double_op_flags: assert property (
    state_r == st_exec && op_r == exclusive_or_double_op |=>
      zero_result_flag == (acc_r == 32'h0000_0000) &&
      negative_result_flag == acc_r[31])
    else $error("double XOR flags wrong");

  a_cmp_keeps_acc: assert property (
    state_r == st_exec && op_r == compare_single_op |=> $stable(acc_r))
    else $error("compare changed accumulator");

  a_cmp_order: assert property (
    state_r == st_exec && op_r == compare_single_op |=>
      less_than_flag == ($past(acc_r[15:0]) < $past(operand_r[15:0])) &&
      equal_flag == ($past(acc_r[15:0]) == $past(operand_r[15:0])) &&
      $onehot({less_than_flag, equal_flag, greater_than_flag}))
    else $error("compare flags wrong");

  a_flags_hold: assert property (
    state_r != st_exec |=> $stable({less_than_flag, equal_flag,
      greater_than_flag, zero_result_flag, negative_result_flag}))
    else $error("flag changed without an operation");

  a_pair_fetch: assert property (
    state_r == st_fetch_lo && is_double(op_r) |=>
      operand_r[15:0] == $past(mem_lo_word) ##1
      operand_r[31:16] == $past(mem_hi_word))
    else $error("operand word pairing wrong");

  a_flags_untouched: assert property (
    state_r == st_exec && op_r == compare_single_op |=>
      $stable({zero_result_flag, negative_result_flag}))
    else $error("compare touched result flags");
endmodule

// File: tb/logic_cmp_unit_tb.sv
// Purpose: Self-checking bench for the logic and compare unit.
// Assumes: AXI4-Lite master tasks; register map of logic_cmp_pkg.
// Notes:   Each operation is checked through ACC, FLAGS and flag ports.
module logic_cmp_unit_tb
  import logic_cmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [REG_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [3:0]        wstrb = 4'h0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic              lt_o, eq_o, gt_o, zero_o, neg_o;
  int                fails = 0, n_checks = 0, cyc = 0;
  logic [1:0]        resp;
  logic [31:0]       rv;

  logic_cmp_unit #(.MEM_WORDS(16)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
    .less_than_flag(lt_o), .equal_flag(eq_o), .greater_than_flag(gt_o),
    .zero_result_flag(zero_o), .negative_result_flag(neg_o));

  always #25 aclk = ~aclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The limit covers every scenario with a wide margin.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      $display("MISMATCH at %0t: timeout", $time);
      test_done;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit got;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        got = 1;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    bit got;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rv = rdata;
        resp = rresp;
        got = 1;
      end
    end
    rready <= 1'b0;
  endtask

  task automatic wm(input int i, input logic [15:0] v);
    wr(OFF_MEM_BASE + 12'(4 * i), {16'h0000, v});
  endtask

  // Starts an operation and polls the busy bit with a bounded count.
  task automatic run(input logic [31:0] cmd);
    wr(OFF_CMD, cmd);
    for (int k = 0; k < 20; k++) begin
      rd(OFF_FLAGS);
      if (rv[FLAG_BUSY] === 1'b0) break;
    end
    chk({31'h0, rv[FLAG_BUSY]}, 32'h0, "operation finished");
  endtask

  task automatic state(input logic [31:0] acc, input logic [4:0] fl);
    rd(OFF_ACC);
    chk(rv, acc, "accumulator");
    rd(OFF_FLAGS);
    chk(rv, {27'h0, fl}, "flags register");
    chk({27'h0, neg_o, zero_o, gt_o, eq_o, lt_o}, {27'h0, fl}, "flag ports");
  endtask

  logic [15:0] cmp_v [3] = '{16'h0005, 16'h0006, 16'h0004};
  int          cmp_b [3] = '{FLAG_EQ, FLAG_LT, FLAG_GT};

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    state(32'h0, 5'h00);
    rd(OFF_IRQ_MASK);
    chk(rv, 32'h0, "mask reset");
    rd(12'h080);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    // Double OR from memory words 2 and 3, with the done interrupt enabled.
    wm(2, 16'h1234);
    wm(3, 16'h8000);
    wr(OFF_ADDR, 32'h2);
    wr(OFF_ACC, 32'h0000_0001);
    wr(OFF_IRQ_MASK, 32'h1);
    run(32'h0);
    state(32'h8000_1235, 5'h10);
    chk({31'h0, irq}, 32'h1, "irq after op");
    wr(OFF_IRQ_STAT, 32'h1);
    rd(OFF_IRQ_STAT);
    chk(rv, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Double XOR with a constant clears the result: zero set, negative off.
    wr(OFF_CONST, 32'h8000_1235);
    run(32'h12);
    state(32'h0, 5'h08);
    // Double OR with an all-ones constant: negative without zero.
    wr(OFF_CONST, 32'hffff_ffff);
    run(32'h10);
    state(32'hffff_ffff, 5'h10);
    wr(OFF_CONST, 32'h0);
    wr(OFF_ACC, 32'h0);
    run(32'h10);
    state(32'h0, 5'h08);
    // Compare low halfword against three memory values; zero flag stays.
    wr(OFF_ADDR, 32'h0);
    wr(OFF_ACC, 32'h0003_0005);
    for (int i = 0; i < 3; i++) begin
      wm(0, cmp_v[i]);
      run(32'h3);
      state(32'h0003_0005, 5'h08 | 5'(1 << cmp_b[i]));
    end
    // Single XOR: low halfword only; compare flags keep their last value.
    wm(1, 16'h00ff);
    wr(OFF_ADDR, 32'h1);
    wr(OFF_ACC, 32'hffff_00ff);
    run(32'h1);
    state(32'h0, 5'h0c);
    run(32'h1);
    state(32'h0000_00ff, 5'h04);
    // Double XOR from memory: low word at ADDR, high word at ADDR+1.
    wm(4, 16'h0f0f);
    wm(5, 16'h00f0);
    wr(OFF_ADDR, 32'h4);
    run(32'h2);
    state(32'h00f0_0ff0, 5'h04);
    test_done;
  end
endmodule
